// [verilog/beh_defs.svh]
// Constants for the bus termination, halt and reset control block.
// Assumes one 100 MHz clock; all counts except BEH_POWERON_MS and BEH_ERR_WORDS are in cycles of that clock.
`ifndef BEH_DEFS_SVH
`define BEH_DEFS_SVH

`define BEH_ADDR_W          24
`define BEH_DATA_W          16
`define BEH_VEC_SSP         24'h000000
`define BEH_VEC_PC          24'h000004
`define BEH_VEC_BUS_FAULT   24'h000008
`define BEH_IMASK_RESET     3'h7
`define BEH_RESET_PULSE_CYC 8'h7c
`define BEH_RESET_HOLD_CYC  8'h0a
`define BEH_ERR_WORDS       3'h4
`define BEH_BUS_WAIT_CYC    8'h04
`define BEH_POWERON_MS      100
`define BEH_CLK_MHZ         100
`define BEH_POWERON_CYC     (`BEH_POWERON_MS * 1000 * `BEH_CLK_MHZ)
`define BEH_WDOG_CYC        8'h20

`endif

// [verilog/beh_pkg.sv]
// Types shared by the processor end and the bench of the bus termination, halt and reset block.
// Assumes beh_defs.svh is compiled alongside.
package beh_pkg;

  typedef enum logic [3:0]
  {
    BEH_IDLE    = 4'h0,
    BEH_ASSERT  = 4'h1,
    BEH_WAIT    = 4'h3,
    BEH_FINISH  = 4'h2,
    BEH_FLOAT   = 4'h6,
    BEH_STACK   = 4'h7,
    BEH_VECTOR  = 4'h5,
    BEH_HALTED  = 4'h4,
    BEH_DBLHALT = 4'hc,
    BEH_RSTVEC  = 4'hd
  } beh_state_type;

  typedef enum logic [1:0]
  {
    BEH_KIND_READ  = 2'h0,
    BEH_KIND_WRITE = 2'h1,
    BEH_KIND_RMW   = 2'h2
  } beh_kind_type;

endpackage : beh_pkg

// [verilog/beh_link_if.sv]
// Link between the processor's bus-termination end and external control logic.
// Assumes both ends share clk_in; two-way reset pin resolved here (active high).
`timescale 1ns/10ps
`include "beh_defs.svh"
interface beh_link_if;
  logic                     address_strobe;
  logic [`BEH_ADDR_W-1:0]   addr;
  logic                     addr_oe;
  logic [`BEH_DATA_W-1:0]   wdata;
  logic                     data_oe;
  logic [2:0]               func_code;
  logic                     write;
  logic                     rmw;
  logic                     transfer_acknowledge;
  logic                     bus_fault_input;
  logic                     halt_ext;
  logic                     reset_dev_oe;
  logic                     reset_ext_oe;
  logic                     reset_line;
  logic                     bus_request;
  logic                     bus_grant;

  // Open-drain reset wire: high while either party drives it.
  assign reset_line = reset_dev_oe | reset_ext_oe;

  modport dev
  (
    output address_strobe, addr, addr_oe, wdata, data_oe, func_code, write, rmw,
    output reset_dev_oe, bus_grant,
    input  transfer_acknowledge, bus_fault_input, halt_ext, reset_line, bus_request
  );

  modport ctl
  (
    input  address_strobe, addr, addr_oe, wdata, data_oe, func_code, write, rmw,
    input  reset_dev_oe, bus_grant, reset_line,
    output transfer_acknowledge, bus_fault_input, halt_ext, reset_ext_oe, bus_request
  );
endinterface : beh_link_if

// [verilog/beh_device.sv]
// Processor end: bus cycle termination, bus-fault exception, re-run, halt,
// single step, double-fault halt and reset sequencing.
// Assumes termination inputs come from logic on clk_in (levels, active high).
`timescale 1ns/10ps
`include "beh_defs.svh"
module beh_device
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  beh_link_if.dev                     link,
  input  wire logic                   cyc_req_in,
  input  wire logic [`BEH_ADDR_W-1:0] cyc_addr_in,
  input  wire logic [`BEH_DATA_W-1:0] cyc_wdata_in,
  input  wire logic [2:0]             cyc_fc_in,
  input  wire beh_pkg::beh_kind_type  cyc_kind_in,
  input  wire logic                   reset_instr_in,
  input  wire logic                   instr_start_in,
  output logic                        cyc_ready_out,
  output logic                        cyc_done_out,
  output logic                        dbl_fault_out,
  output logic                        halted_out,
  output logic [`BEH_ADDR_W-1:0]      fetch_addr_out,
  output logic [3:0]                  stack_step_out,
  output logic [2:0]                  imask_out,
  output logic                        sys_reset_out,
  output beh_pkg::beh_state_type      state_out
);

  beh_pkg::beh_state_type state_ff;
  logic [`BEH_ADDR_W-1:0] addr_ff;
  logic [`BEH_DATA_W-1:0] wdata_ff;
  logic [2:0]             fc_ff;
  beh_pkg::beh_kind_type  kind_ff;
  logic                   in_exc_ff;
  logic                   booted_ff;
  logic [3:0]             step_ff;
  logic [7:0]             rst_pulse_ff;
  logic [7:0]             rst_hold_ff;
  logic [2:0]             imask_ff;
  logic                   fault_seen_ff;
  logic                   halt_seen_ff;
  logic                   grant_ff;
  logic                   sys_reset_ff;
  logic [1:0]             rvec_ff;

  wire fault  = link.bus_fault_input;
  wire halt   = link.halt_ext;
  wire ack    = link.transfer_acknowledge;
  wire is_rmw = (kind_ff == beh_pkg::BEH_KIND_RMW);

  // Reset and halt held together for ten cycles restart the processor.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_hold_ff <= 8'h00;
    else if (!(link.reset_line && halt))
      rst_hold_ff <= 8'h00;
    else if (rst_hold_ff != `BEH_RESET_HOLD_CYC)
      rst_hold_ff <= rst_hold_ff + 8'h01;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sys_reset_ff <= 1'b0;
    else
      sys_reset_ff <= (rst_hold_ff == `BEH_RESET_HOLD_CYC - 8'h01);
  end

  // Reset instruction: drive the reset pin for 124 clocks, no internal effect.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_pulse_ff <= 8'h00;
    else if (reset_instr_in && rst_pulse_ff == 8'h00)
      rst_pulse_ff <= `BEH_RESET_PULSE_CYC;
    else if (rst_pulse_ff != 8'h00)
      rst_pulse_ff <= rst_pulse_ff - 8'h01;
  end

  // Arbitration keeps working in every state, halted or not.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      grant_ff <= 1'b0;
    else
      grant_ff <= link.bus_request && (!link.address_strobe || grant_ff);
  end

  // Termination flags latched during the active cycle.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fault_seen_ff <= 1'b0;
      halt_seen_ff  <= 1'b0;
    end
    else if (state_ff == beh_pkg::BEH_IDLE || (state_ff == beh_pkg::BEH_HALTED && !halt))
    begin
      // A re-run starts clean so that it is judged on its own termination.
      fault_seen_ff <= 1'b0;
      halt_seen_ff  <= 1'b0;
    end
    else if (state_ff == beh_pkg::BEH_ASSERT || state_ff == beh_pkg::BEH_WAIT)
    begin
      fault_seen_ff <= fault_seen_ff | fault;
      halt_seen_ff  <= halt_seen_ff | halt;
    end
  end

  // Main sequencer.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff  <= beh_pkg::BEH_RSTVEC;
      addr_ff   <= '0;
      wdata_ff  <= '0;
      fc_ff     <= 3'h0;
      kind_ff   <= beh_pkg::BEH_KIND_READ;
      in_exc_ff <= 1'b0;
      booted_ff <= 1'b0;
      step_ff   <= 4'h0;
      imask_ff  <= `BEH_IMASK_RESET;
      rvec_ff   <= 2'h0;
    end
    else if (sys_reset_ff)
    begin
      state_ff  <= beh_pkg::BEH_RSTVEC;
      in_exc_ff <= 1'b0;
      booted_ff <= 1'b0;
      imask_ff  <= `BEH_IMASK_RESET;
      rvec_ff   <= 2'h0;
    end
    else
    begin
      if (instr_start_in && state_ff == beh_pkg::BEH_IDLE)
      begin
        in_exc_ff <= 1'b0;
        booted_ff <= 1'b1;
      end
      case (state_ff)
        beh_pkg::BEH_RSTVEC:
        begin
          // Stack pointer fetch first, then program counter.
          if (link.address_strobe && fault)
            state_ff <= beh_pkg::BEH_DBLHALT;
          else if (link.address_strobe && ack)
          begin
            rvec_ff <= rvec_ff + 2'h1;
            if (rvec_ff == 2'h1)
              state_ff <= beh_pkg::BEH_IDLE;
          end
        end
        beh_pkg::BEH_IDLE:
        begin
          if (halt)
            state_ff <= beh_pkg::BEH_IDLE;
          else if (cyc_req_in)
          begin
            addr_ff  <= cyc_addr_in;
            wdata_ff <= cyc_wdata_in;
            fc_ff    <= cyc_fc_in;
            kind_ff  <= cyc_kind_in;
            state_ff <= beh_pkg::BEH_ASSERT;
          end
        end
        beh_pkg::BEH_ASSERT:
          state_ff <= beh_pkg::BEH_WAIT;
        beh_pkg::BEH_WAIT:
        begin
          if (fault || fault_seen_ff)
            state_ff <= beh_pkg::BEH_FINISH;
          else if (ack)
            state_ff <= beh_pkg::BEH_FINISH;
        end
        beh_pkg::BEH_FINISH:
        begin
          if (!fault_seen_ff)
            state_ff <= (halt_seen_ff || halt) ? beh_pkg::BEH_HALTED : beh_pkg::BEH_IDLE;
          else if ((halt_seen_ff || halt) && !is_rmw)
            state_ff <= beh_pkg::BEH_HALTED;
          else if (in_exc_ff || !booted_ff)
            state_ff <= beh_pkg::BEH_DBLHALT;
          else
            state_ff <= beh_pkg::BEH_FLOAT;
        end
        beh_pkg::BEH_FLOAT:
        begin
          if (!fault)
          begin
            state_ff  <= beh_pkg::BEH_STACK;
            in_exc_ff <= 1'b1;
            step_ff   <= 4'h0;
          end
        end
        beh_pkg::BEH_STACK:
        begin
          // Two words of PC and SR, then the error description words.
          if (step_ff == 4'h1 + {1'b0, `BEH_ERR_WORDS})
            state_ff <= beh_pkg::BEH_VECTOR;
          else
            step_ff <= step_ff + 4'h1;
        end
        beh_pkg::BEH_VECTOR:
        begin
          addr_ff  <= `BEH_VEC_BUS_FAULT;
          state_ff <= beh_pkg::BEH_IDLE;
        end
        beh_pkg::BEH_HALTED:
        begin
          // Re-run repeats the held address, data, codes; not an exception.
          if (!halt)
            state_ff <= fault_seen_ff ? beh_pkg::BEH_ASSERT : beh_pkg::BEH_IDLE;
        end
        beh_pkg::BEH_DBLHALT:
          state_ff <= beh_pkg::BEH_DBLHALT;
        default:
          state_ff <= beh_pkg::BEH_IDLE;
      endcase
    end
  end

  wire in_cycle = (state_ff == beh_pkg::BEH_ASSERT) || (state_ff == beh_pkg::BEH_WAIT);
  wire rvec_cyc = (state_ff == beh_pkg::BEH_RSTVEC) && !sys_reset_ff;

  // Strobe drops on leaving the wait, the bus-state-seven point.
  assign link.address_strobe = in_cycle || rvec_cyc;
  assign link.addr           = rvec_cyc ? (rvec_ff[0] ? `BEH_VEC_PC : `BEH_VEC_SSP) : addr_ff;
  assign link.addr_oe        = in_cycle || rvec_cyc;
  assign link.wdata          = wdata_ff;
  assign link.data_oe        = in_cycle && (kind_ff != beh_pkg::BEH_KIND_READ);
  assign link.func_code      = fc_ff;
  assign link.write          = in_cycle && (kind_ff == beh_pkg::BEH_KIND_WRITE);
  assign link.rmw            = in_cycle && is_rmw;
  assign link.reset_dev_oe   = (rst_pulse_ff != 8'h00);
  assign link.bus_grant      = grant_ff;

  assign cyc_ready_out  = (state_ff == beh_pkg::BEH_IDLE) && !halt;
  assign cyc_done_out   = (state_ff == beh_pkg::BEH_FINISH) && !fault_seen_ff;
  assign dbl_fault_out  = (state_ff == beh_pkg::BEH_DBLHALT);
  assign halted_out     = (state_ff == beh_pkg::BEH_HALTED) || dbl_fault_out;
  assign fetch_addr_out = addr_ff;
  assign stack_step_out = step_ff;
  assign imask_out      = imask_ff;
  assign sys_reset_out  = sys_reset_ff;
  assign state_out      = state_ff;

endmodule : beh_device

// [verilog/beh_control.sv]
// External control end: watchdog, termination, halt/step and reset source.
// Assumes the processor end shares clk_in; all link inputs are same-domain.
`timescale 1ns/10ps
`include "beh_defs.svh"
module beh_control
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  beh_link_if.ctl   link,
  input  wire logic slave_ok_in,
  input  wire logic rerun_req_in,
  input  wire logic halt_req_in,
  input  wire logic step_in,
  input  wire logic sys_reset_req_in,
  input  wire logic bus_req_in,
  output logic      bus_grant_out
);

  logic [7:0] wdog_ff;
  logic       ack_ff;
  logic       fault_ff;
  logic       halt_ff;
  logic       rerun_ff;
  logic [7:0] rhold_ff;
  logic       step_ff;

  // All termination outputs change only on rising edges.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      wdog_ff <= 8'h00;
    else if (!link.address_strobe)
      wdog_ff <= 8'h00;
    else if (wdog_ff != `BEH_WDOG_CYC)
      wdog_ff <= wdog_ff + 8'h01;
  end

  wire timeout = (wdog_ff == `BEH_WDOG_CYC);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ack_ff   <= 1'b0;
      fault_ff <= 1'b0;
      rerun_ff <= 1'b0;
    end
    else if (!link.address_strobe)
    begin
      ack_ff   <= 1'b0;
      fault_ff <= 1'b0;
      // The re-run request ends one cycle after the fault, so halt outlasts it once.
      rerun_ff <= rerun_ff && fault_ff;
    end
    else
    begin
      ack_ff   <= slave_ok_in && !rerun_req_in;
      fault_ff <= timeout || rerun_req_in;
      rerun_ff <= rerun_req_in;
    end
  end

  // Single step opens halt for one cycle on a step pulse of one or two cycles; a longer pulse opens it every other cycle.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      step_ff <= 1'b0;
    else
      step_ff <= step_in && !step_ff;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      halt_ff <= 1'b0;
    else if (rerun_ff && (fault_ff || link.address_strobe))
      halt_ff <= 1'b1;
    else
      halt_ff <= (halt_req_in && !step_ff) || rhold_ff != 8'h00;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rhold_ff <= 8'h00;
    else if (sys_reset_req_in && rhold_ff == 8'h00)
      rhold_ff <= `BEH_RESET_HOLD_CYC + 8'h01;
    else if (rhold_ff != 8'h00)
      rhold_ff <= rhold_ff - 8'h01;
  end

  assign link.transfer_acknowledge = ack_ff;
  assign link.bus_fault_input      = fault_ff;
  assign link.halt_ext             = halt_ff;
  assign link.reset_ext_oe         = (rhold_ff != 8'h00);
  assign link.bus_request          = bus_req_in;
  assign bus_grant_out             = link.bus_grant;

endmodule : beh_control

// [verification/beh_link_props.sv]
// Assertions on the link between the processor end and the control end.
// Assumes every link signal changes on clk_in; rst_n_in is async active low.
`timescale 1ns/10ps
`include "beh_defs.svh"
module beh_link_props
(
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire logic                   address_strobe,
  input wire logic [`BEH_ADDR_W-1:0] addr,
  input wire logic                   addr_oe,
  input wire logic [`BEH_DATA_W-1:0] wdata,
  input wire logic                   data_oe,
  input wire logic [2:0]             func_code,
  input wire logic                   write,
  input wire logic                   rmw,
  input wire logic                   transfer_acknowledge,
  input wire logic                   bus_fault_input,
  input wire logic                   halt_ext,
  input wire logic                   reset_dev_oe,
  input wire logic                   reset_ext_oe,
  input wire logic                   reset_line,
  input wire logic                   bus_request,
  input wire logic                   bus_grant
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0]             pulse_cnt_ff;
  logic                   rerun_ff;
  logic                   strobe_ff;
  logic [`BEH_ADDR_W-1:0] raddr_ff;
  logic [`BEH_DATA_W-1:0] rdata_ff;
  logic [2:0]             rfc_ff;
  logic                   rwr_ff;
  logic                   flt_ff;
  logic                   hlt_ff;

  // Counts consecutive cycles in which the processor drives the reset wire.
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      pulse_cnt_ff <= 8'h00;
    else
      pulse_cnt_ff <= reset_dev_oe ? pulse_cnt_ff + 8'h01 : 8'h00;

  // Remembers the last cycle and arms a re-run check when a non-RMW cycle ended by fault and halt.
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      rerun_ff  <= 1'b0;
      strobe_ff <= 1'b0;
      flt_ff    <= 1'b0;
      hlt_ff    <= 1'b0;
      raddr_ff  <= '0;
      rdata_ff  <= '0;
      rfc_ff    <= 3'h0;
      rwr_ff    <= 1'b0;
    end
    else
    begin
      strobe_ff <= address_strobe;
      if (address_strobe)
      begin
        raddr_ff <= addr;
        rdata_ff <= wdata;
        rfc_ff   <= func_code;
        rwr_ff   <= write;
        flt_ff   <= (flt_ff && strobe_ff) || (bus_fault_input && !rmw);
        hlt_ff   <= (hlt_ff && strobe_ff) || halt_ext;
      end
      if (reset_line || (address_strobe && !strobe_ff))
        rerun_ff <= 1'b0;
      else if (strobe_ff && !address_strobe && flt_ff && (hlt_ff || halt_ext))
        rerun_ff <= 1'b1;
    end

  a_fault_ends_cycle: assert property
    (bus_fault_input && address_strobe |-> ##[1:3] !address_strobe)
    else $error("strobe held after bus fault");
  a_fault_floats_bus: assert property
    (bus_fault_input && !address_strobe |-> !addr_oe && !data_oe)
    else $error("buses driven during fault");
  a_halt_no_start: assert property
    (halt_ext && !address_strobe && !reset_line && !$past(reset_line) |=> !address_strobe)
    else $error("cycle started while halted");
  a_rerun_same_cycle: assert property
    ($rose(address_strobe) && rerun_ff |-> addr == raddr_ff && func_code == rfc_ff &&
      write == rwr_ff && (!write || wdata == rdata_ff))
    else $error("re-run cycle differs");
  a_halt_outlasts_fault: assert property
    ($fell(bus_fault_input) && $past(halt_ext) |-> halt_ext)
    else $error("halt dropped with fault");
  a_fault_after_ack: assert property
    ($fell(bus_fault_input) |-> !transfer_acknowledge)
    else $error("fault dropped before acknowledge");
  a_halt_floats_bus: assert property
    (halt_ext && $fell(address_strobe) |=> !addr_oe && !data_oe)
    else $error("buses driven after halted cycle");
  a_reset_pulse_len: assert property
    ($fell(reset_dev_oe) |-> pulse_cnt_ff == 8'h7c)
    else $error("reset pulse length wrong");
  a_reset_pulse_max: assert property
    (pulse_cnt_ff <= 8'h7c)
    else $error("reset pulse too long");

  c_rerun: cover property ($rose(address_strobe) && rerun_ff);
  c_reset_pulse: cover property ($fell(reset_dev_oe));
  c_fault: cover property (bus_fault_input && address_strobe);
  c_grant: cover property (bus_grant && halt_ext);
endmodule : beh_link_props

// [verification/test_bus_error_halt_reset_control.sv]
// Bench joining the processor end and the control end through the link.
// Assumes both ends share one 100 MHz clock and an async active-low reset.
`timescale 1ns/10ps
`include "beh_defs.svh"
`define W(c) for (int i = 0; i < 500 && !(c); i++) @(negedge clk_in);
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module test_bus_error_halt_reset_control;
  logic clk_in, rst_n_in, cyc_req, rst_instr, instr_start, slave_ok, rerun, halt_req;
  logic step, sys_req, bus_req, ready, done, dbl, halted, sys_rst, grant;
  logic [`BEH_ADDR_W-1:0] cyc_addr, fetch;
  logic [`BEH_DATA_W-1:0] cyc_wdata;
  logic [2:0]             cyc_fc, imask;
  logic [3:0]             stack;
  beh_pkg::beh_kind_type  cyc_kind;
  beh_pkg::beh_state_type state;
  int num_errors, samples_checked, seed, n;
  beh_link_if lk();
  beh_device beh_device_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(lk), .cyc_req_in(cyc_req),
    .cyc_addr_in(cyc_addr), .cyc_wdata_in(cyc_wdata), .cyc_fc_in(cyc_fc), .cyc_kind_in(cyc_kind),
    .reset_instr_in(rst_instr), .instr_start_in(instr_start), .cyc_ready_out(ready),
    .cyc_done_out(done), .dbl_fault_out(dbl), .halted_out(halted), .fetch_addr_out(fetch),
    .stack_step_out(stack), .imask_out(imask), .sys_reset_out(sys_rst), .state_out(state));
  beh_control beh_control_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(lk),
    .slave_ok_in(slave_ok), .rerun_req_in(rerun), .halt_req_in(halt_req), .step_in(step),
    .sys_reset_req_in(sys_req), .bus_req_in(bus_req), .bus_grant_out(grant));
  beh_link_props beh_link_props_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .address_strobe(lk.address_strobe), .addr(lk.addr), .addr_oe(lk.addr_oe),
    .wdata(lk.wdata), .data_oe(lk.data_oe), .func_code(lk.func_code), .write(lk.write),
    .rmw(lk.rmw), .transfer_acknowledge(lk.transfer_acknowledge),
    .bus_fault_input(lk.bus_fault_input), .halt_ext(lk.halt_ext),
    .reset_dev_oe(lk.reset_dev_oe), .reset_ext_oe(lk.reset_ext_oe),
    .reset_line(lk.reset_line), .bus_request(lk.bus_request), .bus_grant(lk.bus_grant));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Starts one cycle with random address, data and code, and checks the address on the bus.
  task automatic run_cyc(input beh_pkg::beh_kind_type k);
    @(posedge clk_in);
    cyc_addr  <= 24'($random(seed));
    cyc_wdata <= 16'($random(seed));
    cyc_fc    <= 3'($random(seed));
    cyc_kind  <= k;
    cyc_req   <= 1'b1;
    @(negedge clk_in);
    `W(lk.address_strobe)
    `CHK("addr", cyc_addr, lk.addr)
    @(posedge clk_in);
    cyc_req <= 1'b0;
  endtask : run_cyc

  task automatic pulse_start();
    @(posedge clk_in);
    instr_start <= 1'b1;
    @(posedge clk_in);
    instr_start <= 1'b0;
  endtask : pulse_start

  task automatic do_reset();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
  endtask : do_reset

  initial
  begin
    #300000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    {cyc_req, rst_instr, instr_start, slave_ok, rerun, halt_req, step, sys_req, bus_req} = '0;
    {cyc_addr, cyc_wdata, cyc_fc, n, num_errors, samples_checked} = '0;
    cyc_kind = beh_pkg::BEH_KIND_READ;
    seed     = 74;
    rst_n_in = 1'b0;
    do_reset();
    `W(dbl)
    `CHK("boot fault", 1'b1, dbl)
    repeat (40) @(negedge clk_in);
    `CHK("still halted", 1'b1, halted)
    @(posedge clk_in);
    slave_ok <= 1'b1;
    do_reset();
    `W(state === beh_pkg::BEH_IDLE)
    `CHK("imask", 3'h7, imask)
    pulse_start();
    for (int j = 0; j < 6; j++)
    begin
      run_cyc(($random(seed) & 1) ? beh_pkg::BEH_KIND_WRITE : beh_pkg::BEH_KIND_READ);
      `W(done)
      `CHK("done", 1'b1, done)
    end
    @(posedge clk_in);
    rerun    <= 1'b1;
    slave_ok <= 1'b0;
    run_cyc(beh_pkg::BEH_KIND_RMW);
    `W(!lk.address_strobe)
    @(posedge clk_in);
    rerun    <= 1'b0;
    slave_ok <= 1'b1;
    @(negedge clk_in);
    `W(state === beh_pkg::BEH_IDLE)
    `CHK("rmw vector", 24'h000008, fetch)
    `CHK("rmw dbl", 1'b0, dbl)
    `CHK("stack words", 4'h1 + `BEH_ERR_WORDS, stack)
    `CHK("ready", 1'b1, ready)
    pulse_start();
    rerun    <= 1'b1;
    slave_ok <= 1'b0;
    run_cyc(beh_pkg::BEH_KIND_WRITE);
    `W(halted)
    `CHK("rerun halt", 1'b1, halted)
    @(posedge clk_in);
    rerun    <= 1'b0;
    slave_ok <= 1'b1;
    `W(done)
    `CHK("rerun done", 1'b1, done)
    `CHK("rerun dbl", 1'b0, dbl)
    @(posedge clk_in);
    slave_ok <= 1'b0;
    run_cyc(beh_pkg::BEH_KIND_READ);
    `W(state === beh_pkg::BEH_IDLE)
    `CHK("first fault", 1'b0, dbl)
    run_cyc(beh_pkg::BEH_KIND_READ);
    `W(dbl)
    `CHK("double fault", 1'b1, dbl)
    @(posedge clk_in);
    slave_ok <= 1'b1;
    sys_req  <= 1'b1;
    halt_req <= 1'b1;
    @(posedge clk_in);
    sys_req <= 1'b0;
    @(negedge clk_in);
    `W(sys_rst)
    `CHK("sys reset", 1'b1, sys_rst)
    repeat (8) @(posedge clk_in);
    halt_req <= 1'b0;
    @(negedge clk_in);
    `W(state === beh_pkg::BEH_IDLE)
    `CHK("left dbl", 1'b0, dbl)
    @(posedge clk_in);
    halt_req <= 1'b1;
    bus_req  <= 1'b1;
    @(negedge clk_in);
    `W(grant)
    `CHK("grant", 1'b1, grant)
    @(posedge clk_in);
    bus_req <= 1'b0;
    cyc_req <= 1'b1;
    repeat (20) @(negedge clk_in);
    `CHK("held", 1'b0, lk.address_strobe)
    `CHK("not ready", 1'b0, ready)
    @(posedge clk_in);
    step <= 1'b1;
    @(posedge clk_in);
    step <= 1'b0;
    `W(lk.address_strobe)
    @(posedge clk_in);
    cyc_req <= 1'b0;
    @(negedge clk_in);
    `W(done)
    `CHK("step done", 1'b1, done)
    `W(halted)
    `CHK("step halted", 1'b1, halted)
    @(posedge clk_in);
    halt_req <= 1'b0;
    @(negedge clk_in);
    `W(state === beh_pkg::BEH_IDLE)
    @(posedge clk_in);
    rst_instr <= 1'b1;
    @(posedge clk_in);
    rst_instr <= 1'b0;
    @(negedge clk_in);
    `W(lk.reset_dev_oe)
    for (n = 0; n < 300 && lk.reset_dev_oe; n++) @(negedge clk_in);
    `CHK("pulse", 124, n)
    `CHK("imask kept", 3'h7, imask)
    finish_test();
  end
endmodule : test_bus_error_halt_reset_control
